//--- hdl/press_regs_pkg.sv
// constants, field layouts and carrier types for the pressure register bank
// assumes a byte-wide register port driven by a serial slave on the same clock
package press_regs_pkg;

    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;

    localparam logic [6:0] ADDR_REF_LOW     = 7'h08;
    localparam logic [6:0] ADDR_REF_MID     = 7'h09;
    localparam logic [6:0] ADDR_REF_HIGH    = 7'h0A;
    localparam logic [6:0] ADDR_IDENT       = 7'h0F;
    localparam logic [6:0] ADDR_AVG_SETUP   = 7'h10;
    localparam logic [6:0] ADDR_CTRL_ONE    = 7'h20;
    localparam logic [6:0] ADDR_CTRL_TWO    = 7'h21;
    localparam logic [6:0] ADDR_CTRL_THREE  = 7'h22;
    localparam logic [6:0] ADDR_INT_SETUP   = 7'h23;
    localparam logic [6:0] ADDR_INT_ORIGIN  = 7'h24;
    localparam logic [6:0] ADDR_THS_LOW     = 7'h25;
    localparam logic [6:0] ADDR_THS_HIGH    = 7'h26;
    localparam logic [6:0] ADDR_SAMPLE_ST   = 7'h27;
    localparam logic [6:0] ADDR_PRESS_LOW   = 7'h28;
    localparam logic [6:0] ADDR_PRESS_MID   = 7'h29;
    localparam logic [6:0] ADDR_PRESS_HIGH  = 7'h2A;
    localparam logic [6:0] ADDR_TEMP_LOW    = 7'h2B;
    localparam logic [6:0] ADDR_TEMP_HIGH   = 7'h2C;
    localparam logic [6:0] ADDR_AMPLIFIER_CONTROL    = 7'h30;

    localparam logic [7:0] RST_REF          = 8'h00;
    localparam logic [7:0] RST_AVG_SETUP    = 8'h7A;
    localparam logic [7:0] RST_CTRL         = 8'h00;
    localparam logic [7:0] RST_AMPLIFIER_CONTROL     = 8'h00;
    localparam logic [7:0] IDENT_VALUE      = 8'h5C;  // arbitrary value
    localparam logic [7:0] READ_NONE        = 8'h00;

    localparam int unsigned PRESSURE_AVERAGE_COUNT_LSB        = 0;
    localparam int unsigned TEMPERATURE_AVERAGE_COUNT_LSB        = 4;
    localparam logic [3:0]  PRESSURE_AVERAGE_COUNT_CODE_256   = 4'h8;
    localparam logic [3:0]  PRESSURE_AVERAGE_COUNT_CODE_384   = 4'h9;
    localparam logic [3:0]  PRESSURE_AVERAGE_COUNT_CODE_512   = 4'hA;
    localparam logic [9:0]  AVG_COUNT_384   = 10'h180;
    localparam logic [9:0]  AVG_COUNT_512   = 10'h200;
    localparam logic [9:0]  AVG_COUNT_ONE   = 10'h001;
    localparam logic [7:0]  AVG_SETUP_MASK  = 8'h7F;

    // one register access from the serial front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       first;
        logic       incr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // measurement taken from the sensing path
    typedef struct packed {
        logic        valid;
        logic [23:0] pressure;
        logic [15:0] temperature;
        logic [7:0]  status;
        logic [7:0]  origin;
    } sample_type;

    typedef enum logic [1:0] {
        BOOT_LOAD,
        BOOT_RUN
    } boot_state_type;

    typedef struct packed {
        boot_state_type state;
        logic [6:0]     next_addr;
        logic [23:0]    ref_val;
        logic [7:0]     avg_setup;
        logic [7:0]     ctrl_one;
        logic [7:0]     ctrl_two;
        logic [7:0]     ctrl_three;
        logic [7:0]     int_setup;
        logic [7:0]     ths_low;
        logic [7:0]     ths_high;
        logic [7:0]     amplifier_control;
        logic [23:0]    press_out;
        logic [15:0]    temp_out;
        logic [7:0]     status;
        logic [7:0]     origin;
        logic [7:0]     rdata;
    } bank_state_type;

endpackage

//--- hdl/avg_decode.sv
// decodes averaging codes into sample counts
// assumes codes straight from the averaging setup register
`timescale 1ns/1ns
module avg_decode
(
    // codes
    input  wire logic [3:0] press_code_in,
    input  wire logic [2:0] temp_code_in,
    // counts
    output logic      [9:0] press_count_out,
    output logic      [7:0] temp_count_out
);

    always_comb
    begin
        case (press_code_in)
            press_regs_pkg::PRESSURE_AVERAGE_COUNT_CODE_256: press_count_out = 10'h100;  // RQ7
            press_regs_pkg::PRESSURE_AVERAGE_COUNT_CODE_384: press_count_out = press_regs_pkg::AVG_COUNT_384;
            press_regs_pkg::PRESSURE_AVERAGE_COUNT_CODE_512: press_count_out = press_regs_pkg::AVG_COUNT_512;
            default:
            begin
                // codes above 1010 are undefined; treat as single sample
                if (press_code_in[3])
                    press_count_out = press_regs_pkg::AVG_COUNT_ONE;
                else
                    press_count_out = 10'((press_regs_pkg::AVG_COUNT_ONE) << press_code_in[2:0]);
            end
        endcase
        temp_count_out = 8'(8'h01 << temp_code_in);  // RQ8
    end

endmodule

//--- hdl/ref_adder.sv
// adds the signed reference pressure to the raw sensed pressure
// assumes both inputs are 24-bit two's complement, result wraps
`timescale 1ns/1ns
module ref_adder
(
    // operands
    input  wire logic [23:0] raw_in,
    input  wire logic [23:0] ref_in,
    // result
    output logic      [23:0] sum_out
);

    assign sum_out = raw_in + ref_in;  // RQ4

endmodule

//--- hdl/press_reg_bank.sv
// register bank of a barometric pressure sensor
// assumes a serial slave on clk_in hands over byte accesses as reg_req_type
// Behaviour
// RQ1: registers are selected by a 7-bit address from the serial port
// RQ2: all registers 8 bits at fixed addresses; controls 20h-22h, status 27h
// RQ3: reference pressure is 24-bit signed over 08h, 09h, 0Ah, read/write
// RQ4: reference pressure is added to the sensed pressure for the output
// RQ5: the three reference bytes reset to zero
// RQ6: identifier at 0Fh returns a fixed code; writes do not change it
// RQ7: pressure average code selects 2^code, or 256, 384, 512
// RQ8: temperature average code selects 2^code, 1 to 128; bit 7 reserved
// RQ9: host avoids 7Ah averaging setup at the fastest output rate; host model only swaps 7Ah writes to 10h for 6Ah while ctrl_q[6:4] is 7
// RQ10: host never writes the reserved address ranges; host model drops first-byte writes there, not burst bytes
// RQ11: host leaves boot-loaded calibration registers alone; host model drops first-byte writes to 30h only
// RQ12: calibration content is reloaded at every power-up
// RQ13: two-wire sub-address top bit requests address auto-increment
// RQ14: four-wire increment bit advances address per data byte, else fixed
// RQ15: writes to read-only registers are ignored
`timescale 1ns/1ns
module press_reg_bank
(
    // clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rstn_in,
    // register port from serial slave
    input  wire press_regs_pkg::reg_req_type req_in,
    output logic                     [7:0]  rdata_out,
    // calibration store
    input  wire logic                [7:0]  calib_amp_in,
    // sensing path
    input  wire press_regs_pkg::sample_type sample_in,
    // configuration outputs and calibration-done flag
    output logic                     [9:0]  press_avg_out,
    output logic                     [7:0]  temp_avg_out,
    output logic                     [7:0]  ctrl_one_out,
    output logic                     [7:0]  ctrl_two_out,
    output logic                     [7:0]  ctrl_three_out,
    output logic                            calib_done_out
);

    press_regs_pkg::bank_state_type st_q;
    press_regs_pkg::bank_state_type st_d;
    logic [23:0] sum_w;
    logic [6:0]  addr_w;
    logic [7:0]  rd_w;

    ref_adder u_ref_adder
    (
        .raw_in  (sample_in.pressure),
        .ref_in  (st_q.ref_val),
        .sum_out (sum_w)
    );

    avg_decode u_avg_decode
    (
        .press_code_in   (st_q.avg_setup[press_regs_pkg::PRESSURE_AVERAGE_COUNT_LSB +: 4]),
        .temp_code_in    (st_q.avg_setup[press_regs_pkg::TEMPERATURE_AVERAGE_COUNT_LSB +: 3]),
        .press_count_out (press_avg_out),
        .temp_count_out  (temp_avg_out)
    );

    // first byte uses its own address, later bytes the tracked one
    always_comb
    begin
        if (req_in.first)
            addr_w = req_in.addr;  // RQ1
        else
            addr_w = st_q.next_addr;
    end

    always_comb
    begin
        case (addr_w)  // RQ2
            press_regs_pkg::ADDR_REF_LOW:    rd_w = st_q.ref_val[7:0];
            press_regs_pkg::ADDR_REF_MID:    rd_w = st_q.ref_val[15:8];
            press_regs_pkg::ADDR_REF_HIGH:   rd_w = st_q.ref_val[23:16];  // RQ3
            press_regs_pkg::ADDR_IDENT:      rd_w = press_regs_pkg::IDENT_VALUE;  // RQ6
            press_regs_pkg::ADDR_AVG_SETUP:  rd_w = st_q.avg_setup;
            press_regs_pkg::ADDR_CTRL_ONE:   rd_w = st_q.ctrl_one;
            press_regs_pkg::ADDR_CTRL_TWO:   rd_w = st_q.ctrl_two;
            press_regs_pkg::ADDR_CTRL_THREE: rd_w = st_q.ctrl_three;
            press_regs_pkg::ADDR_INT_SETUP:  rd_w = st_q.int_setup;
            press_regs_pkg::ADDR_INT_ORIGIN: rd_w = st_q.origin;
            press_regs_pkg::ADDR_THS_LOW:    rd_w = st_q.ths_low;
            press_regs_pkg::ADDR_THS_HIGH:   rd_w = st_q.ths_high;
            press_regs_pkg::ADDR_SAMPLE_ST:  rd_w = st_q.status;
            press_regs_pkg::ADDR_PRESS_LOW:  rd_w = st_q.press_out[7:0];
            press_regs_pkg::ADDR_PRESS_MID:  rd_w = st_q.press_out[15:8];
            press_regs_pkg::ADDR_PRESS_HIGH: rd_w = st_q.press_out[23:16];
            press_regs_pkg::ADDR_TEMP_LOW:   rd_w = st_q.temp_out[7:0];
            press_regs_pkg::ADDR_TEMP_HIGH:  rd_w = st_q.temp_out[15:8];
            press_regs_pkg::ADDR_AMPLIFIER_CONTROL:   rd_w = st_q.amplifier_control;
            default:                         rd_w = press_regs_pkg::READ_NONE;
        endcase
    end

    always_comb
    begin
        st_d = st_q;
        case (st_q.state)
            press_regs_pkg::BOOT_LOAD:
            begin
                // trimming copied once after power-up release
                st_d.amplifier_control = calib_amp_in;  // RQ12
                st_d.state    = press_regs_pkg::BOOT_RUN;
            end
            press_regs_pkg::BOOT_RUN:
            begin
                if (req_in.wr || req_in.rd)
                begin
                    if (req_in.incr)
                        st_d.next_addr = 7'(addr_w + 7'h01);  // RQ13 RQ14
                    else
                        st_d.next_addr = addr_w;  // RQ14
                end
                if (req_in.rd)
                    st_d.rdata = rd_w;
                if (req_in.wr)
                begin
                    // read-only and reserved addresses fall to default
                    case (addr_w)  // RQ15
                        press_regs_pkg::ADDR_REF_LOW:    st_d.ref_val[7:0]   = req_in.wdata;
                        press_regs_pkg::ADDR_REF_MID:    st_d.ref_val[15:8]  = req_in.wdata;
                        press_regs_pkg::ADDR_REF_HIGH:   st_d.ref_val[23:16] = req_in.wdata;
                        press_regs_pkg::ADDR_AVG_SETUP:
                            st_d.avg_setup = req_in.wdata & press_regs_pkg::AVG_SETUP_MASK;
                        press_regs_pkg::ADDR_CTRL_ONE:   st_d.ctrl_one   = req_in.wdata;
                        press_regs_pkg::ADDR_CTRL_TWO:   st_d.ctrl_two   = req_in.wdata;
                        press_regs_pkg::ADDR_CTRL_THREE: st_d.ctrl_three = req_in.wdata;
                        press_regs_pkg::ADDR_INT_SETUP:  st_d.int_setup  = req_in.wdata;
                        press_regs_pkg::ADDR_THS_LOW:    st_d.ths_low    = req_in.wdata;
                        press_regs_pkg::ADDR_THS_HIGH:   st_d.ths_high   = req_in.wdata;
                        press_regs_pkg::ADDR_AMPLIFIER_CONTROL:   st_d.amplifier_control   = req_in.wdata;
                        default:                         st_d.amplifier_control   = st_q.amplifier_control;
                    endcase
                end
                if (sample_in.valid)
                begin
                    st_d.press_out = sum_w;  // RQ4
                    st_d.temp_out  = sample_in.temperature;
                    st_d.status    = sample_in.status;
                    st_d.origin    = sample_in.origin;
                end
            end
            default:
                st_d.state = press_regs_pkg::BOOT_LOAD;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_q            <= '0;
            st_q.state      <= press_regs_pkg::BOOT_LOAD;
            st_q.ref_val    <= {3{press_regs_pkg::RST_REF}};  // RQ5
            st_q.avg_setup  <= press_regs_pkg::RST_AVG_SETUP;
            st_q.ctrl_one   <= press_regs_pkg::RST_CTRL;
            st_q.ctrl_two   <= press_regs_pkg::RST_CTRL;
            st_q.ctrl_three <= press_regs_pkg::RST_CTRL;
            st_q.amplifier_control   <= press_regs_pkg::RST_AMPLIFIER_CONTROL;
        end
        else
            st_q <= st_d;
    end

    assign rdata_out      = st_q.rdata;
    assign ctrl_one_out   = st_q.ctrl_one;
    assign ctrl_two_out   = st_q.ctrl_two;
    assign ctrl_three_out = st_q.ctrl_three;
    assign calib_done_out = (st_q.state == press_regs_pkg::BOOT_RUN);

    a_ref_reset_zero: assert property (@(posedge clk_in)  // RQ5
        $rose(rstn_in) |-> st_q.ref_val == 24'h000000)
        else $error("reference not zero after reset");

    a_ident_read_fixed: assert property (@(posedge clk_in) disable iff (!rstn_in)  // RQ6
        (req_in.rd && addr_w == press_regs_pkg::ADDR_IDENT && calib_done_out)
        |=> rdata_out == press_regs_pkg::IDENT_VALUE)
        else $error("identifier read wrong");

    a_ref_write_low: assert property (@(posedge clk_in) disable iff (!rstn_in)  // RQ3
        (req_in.wr && addr_w == press_regs_pkg::ADDR_REF_LOW && calib_done_out)
        |=> st_q.ref_val[7:0] == $past(req_in.wdata))
        else $error("reference low write lost");

    a_sum_output: assert property (@(posedge clk_in) disable iff (!rstn_in)  // RQ4
        (sample_in.valid && calib_done_out && !(req_in.wr && addr_w[6:2] == 5'h02))
        |=> st_q.press_out == 24'($past(sample_in.pressure) + st_q.ref_val))
        else $error("pressure output not offset by reference");

    a_ro_write_ignored: assert property (@(posedge clk_in) disable iff (!rstn_in)  // RQ15
        (req_in.wr && addr_w == press_regs_pkg::ADDR_TEMP_LOW && !sample_in.valid)
        |=> $stable(st_q.temp_out))
        else $error("read-only register changed by write");

    a_incr_addr: assert property (@(posedge clk_in) disable iff (!rstn_in)  // RQ14
        (calib_done_out && req_in.rd && req_in.incr)
        |=> st_q.next_addr == 7'($past(addr_w) + 7'h01))
        else $error("address did not advance");

    a_fixed_addr: assert property (@(posedge clk_in) disable iff (!rstn_in)  // RQ14
        (calib_done_out && req_in.wr && !req_in.incr)
        |=> st_q.next_addr == $past(addr_w))
        else $error("address moved without increment");

    a_boot_reload: assert property (@(posedge clk_in)  // RQ12
        $rose(rstn_in) ##1 1'b1 |-> calib_done_out && st_q.amplifier_control == $past(calib_amp_in))
        else $error("calibration not reloaded");

    a_avg_count: assert property (@(posedge clk_in) disable iff (!rstn_in)  // RQ7
        st_q.avg_setup[3:0] == press_regs_pkg::PRESSURE_AVERAGE_COUNT_CODE_384 |-> press_avg_out == 10'h180)
        else $error("pressure average count wrong");

    a_avg_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in)  // RQ8
        st_q.avg_setup[7] == 1'b0 && temp_avg_out == 8'(8'h01 << st_q.avg_setup[6:4]))
        else $error("temperature averaging field wrong");

endmodule

//--- verif/host_model.sv
// host model issuing byte accesses to the register bank, one per clock
// assumes callers start after boot load and end each group with idle
`timescale 1ns/1ns
module host_model
(
    // clock
    input  wire logic                   clk_in,
    // register port
    output press_regs_pkg::reg_req_type req_out
);
    logic [7:0] ctrl_q;

    initial
    begin
        req_out = '0;
        ctrl_q  = 8'h00;
    end

    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
                          input logic f, input logic i);
        logic [7:0] v;
        v = d;
        // reserved writes may damage the part, so first-byte writes to 00h-07h, 0Dh, 0Eh, 11h-1Fh and 2Dh-2Fh never leave the host; burst bytes are not checked
        if (w && f && (a < 7'h08 || a == 7'h0D || a == 7'h0E
            || (a > 7'h10 && a < 7'h20) || (a > 7'h2C && a < 7'h30)))
            return;
        if (w && f && a == 7'h30)
            return;
        if (w && f && a == 7'h20)
            ctrl_q = d;
        if (w && f && a == 7'h10 && d == 8'h7A && ctrl_q[6:4] == 3'h7)
            v = 8'h6A;
        @(posedge clk_in);
        req_out <= '{wr: w, rd: !w, first: f, incr: i, addr: a, wdata: v};
    endtask

    // released lines stop showing the old value
    task automatic idle();
        @(posedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, first: 1'b0, incr: 1'b0,
                     addr: ~req_out.addr, wdata: ~req_out.wdata};
    endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the pressure register bank
// assumes read data stands one cycle after each read strobe
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [7:0] data;
        logic       avg;
        logic [9:0] pavg;
        logic [7:0] tavg;
    } note_type;
    localparam logic [6:0] RA [13] = '{7'h08, 7'h09, 7'h0A, 7'h0F, 7'h10, 7'h20, 7'h21,
                                       7'h22, 7'h23, 7'h25, 7'h26, 7'h05, 7'h2D};
    localparam logic [6:0] RO [6] = '{7'h0F, 7'h24, 7'h27, 7'h28, 7'h2B, 7'h2C};
    logic                        clk_in;
    logic                        rstn_in;
    logic [7:0]                  calib;
    logic [7:0]                  rdata;
    logic [9:0]                  pavg;
    logic [7:0]                  tavg;
    logic [7:0]                  ctrl1;
    logic [7:0]                  ctrl2;
    logic [7:0]                  ctrl3;
    logic                        done;
    logic                        rd_pend;
    logic [23:0]                 refv;
    logic [39:0]                 outs;
    logic [7:0]                  d;
    press_regs_pkg::reg_req_type req;
    press_regs_pkg::sample_type  smp;
    note_type                    nt;
    note_type                    exp_q[$];
    int                          n_errors = 0;
    int                          checks = 0;

    always #4 clk_in = ~clk_in;

    host_model host_u (.clk_in(clk_in), .req_out(req));

    press_reg_bank dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req), .rdata_out(rdata),
        .calib_amp_in(calib), .sample_in(smp), .press_avg_out(pavg), .temp_avg_out(tavg),
        .ctrl_one_out(ctrl1), .ctrl_two_out(ctrl2), .ctrl_three_out(ctrl3),
        .calib_done_out(done));

    task automatic fail(input string m);
        n_errors++;
        $display("ERROR %0t: %s", $time, m);
    endtask

    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        checks++;
        if (g !== e)
            fail("output mismatch");
    endtask

    task automatic rd(input logic [6:0] a, input logic f, input logic i, input logic [7:0] e);
        exp_q.push_back('{e, 1'b0, 10'h000, 8'h00});
        host_u.access(1'b0, a, 8'h00, f, i);
    endtask

    task automatic avg_rd(input logic [7:0] e, input logic [9:0] p, input logic [7:0] t);
        exp_q.push_back('{e, 1'b1, p, t});
        host_u.access(1'b0, 7'h10, 8'h00, 1'b1, 1'b0);
    endtask

    // codes above 0Ah give one average by choice
    function automatic logic [9:0] pcount(input logic [3:0] c);
        if (c < 4'h8)
            return 10'h001 << c;
        return (c == 4'h8) ? 10'h100 : (c == 4'h9) ? 10'h180 : (c == 4'hA) ? 10'h200 : 10'h001;
    endfunction

    task automatic do_reset();
        @(posedge clk_in);
        rstn_in <= 1'b0;
        calib   <= 8'($urandom);
        repeat (20) @(posedge clk_in);
        chk({9'h000, done}, 10'h000);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk({9'h000, done}, 10'h001);
    endtask

    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // result watcher: oldest note against each answered read
    always @(posedge clk_in)
    begin
        if (rd_pend)
        begin
            checks++;
            if (exp_q.size() == 0)
                fail("read without note");
            else
            begin
                nt = exp_q.pop_front();
                if (rdata !== nt.data)
                    fail("read data");
                if (nt.avg && (pavg !== nt.pavg || tavg !== nt.tavg))
                    fail("averaging count");
            end
        end
        rd_pend <= req.rd;
    end

    initial
    begin
        #(8 * 4000);
        fail("run did not finish");
        wrap_up();
    end

    initial
    begin
        void'($urandom(33939));
        clk_in  = 1'b0;
        rstn_in = 1'b0;
        calib   = 8'h00;
        smp     = '0;
        rd_pend = 1'b0;
        do_reset();
        for (int k = 0; k < 13; k++)
            rd(RA[k], 1'b1, 1'b0, (k == 3) ? press_regs_pkg::IDENT_VALUE : (k == 4) ? 8'h7A : 8'h00);
        rd(7'h30, 1'b1, 1'b0, calib);
        host_u.idle();
        #1;
        chk({2'b00, ctrl1 | ctrl2 | ctrl3}, 10'h000);
        chk(pavg, 10'h200);
        chk({2'b00, tavg}, 10'h080);
        // negative reference over an incrementing burst, then one sample
        refv = 24'($urandom) | 24'h800000;
        for (int k = 0; k < 3; k++)
            host_u.access(1'b1, 7'(8 + k), refv[8*k +: 8], k == 0, 1'b1);
        for (int k = 0; k < 3; k++)
            rd(7'(8 + k), k == 0, 1'b1, refv[8*k +: 8]);
        host_u.idle();
        smp <= '{1'b1, 24'($urandom), 16'($urandom), 8'($urandom), 8'($urandom)};
        host_u.idle();
        smp.valid <= 1'b0;
        #1;
        outs = {smp.temperature, smp.pressure + refv};
        for (int k = 0; k < 5; k++)
            rd(7'(8'h28 + k), k == 0, 1'b1, outs[8*k +: 8]);
        // read-only places keep their content
        foreach (RO[k])
            host_u.access(1'b1, RO[k], 8'($urandom), 1'b1, 1'b0);
        rd(7'h0F, 1'b1, 1'b0, press_regs_pkg::IDENT_VALUE);
        rd(7'h24, 1'b1, 1'b0, smp.origin);
        rd(7'h27, 1'b1, 1'b0, smp.status);
        rd(7'h28, 1'b1, 1'b0, outs[7:0]);
        rd(7'h2B, 1'b1, 1'b0, outs[31:24]);
        rd(7'h2C, 1'b1, 1'b0, outs[39:32]);
        // fixed address burst stays on the first register
        d = 8'($urandom);
        host_u.access(1'b1, 7'h20, ~d, 1'b1, 1'b0);
        host_u.access(1'b1, 7'h21, d, 1'b0, 1'b0);
        rd(7'h21, 1'b1, 1'b0, 8'h00);
        rd(7'h20, 1'b1, 1'b0, d);
        host_u.idle();
        #1;
        chk({2'b00, ctrl1}, {2'b00, d});
        host_u.access(1'b1, 7'h20, 8'h70, 1'b1, 1'b0);
        host_u.access(1'b1, 7'h10, 8'h7A, 1'b1, 1'b0);
        avg_rd(8'h6A, 10'h200, 8'h40);
        host_u.access(1'b1, 7'h20, 8'h00, 1'b1, 1'b0);
        for (int c = 0; c < 16; c++)
        begin
            d = {1'b1, 3'(c), 4'(c)};
            host_u.access(1'b1, 7'h10, d, 1'b1, 1'b0);
            avg_rd({1'b0, d[6:0]}, pcount(d[3:0]), 8'h01 << d[6:4]);
        end
        host_u.idle();
        // power cycle in mid-run reloads calibration
        do_reset();
        rd(7'h30, 1'b1, 1'b0, calib);
        rd(7'h08, 1'b1, 1'b0, 8'h00);
        host_u.idle();
        repeat (3) @(posedge clk_in);
        chk(10'(exp_q.size()), 10'h000);
        wrap_up();
    end
endmodule
